// ---- hw/eabr_decode.sv ----
// Purpose: Decodes one instruction word into branch fields
// Assumes: Word arrives in the same cycle as the issue strobe
// Notes: Purely combinational
`timescale 1ns/1ps
`include "eabr_consts.svh"
module eabr_decode
(
  // Instruction
  input wire logic [31:0] i_instr,
  // Decoded fields
  output eabr_pkg::eabr_decode_type o_dec
);
  logic is_reg;
  logic is_imm;
  logic [1:0] cond;

  always_comb
  begin
    cond = i_instr[`EABR_COND_HI:`EABR_COND_LO];
    is_reg = (i_instr[`EABR_OPC_HI:`EABR_OPC_LO] == `EABR_OPC_REG) &&
      (i_instr[`EABR_ZERO_HI:`EABR_ZERO_LO] ==
      (11'h001 << `EABR_LONG_BIT) ||
      i_instr[`EABR_ZERO_HI:`EABR_ZERO_LO] == 11'h000);
    is_imm = (i_instr[`EABR_OPC_HI:`EABR_OPC_LO] == `EABR_OPC_IMM);
    o_dec.valid = (is_reg || is_imm) &&
      (i_instr[`EABR_EA_HI:`EABR_EA_LO] == `EABR_EA_VAL) &&
      (cond == `EABR_COND_LT || cond == `EABR_COND_NE);
    o_dec.imm_form = is_imm;
    o_dec.is_lt = (cond == `EABR_COND_LT);
    o_dec.dslot = i_instr[`EABR_DSLOT_BIT];
    o_dec.long_cmp = is_reg && i_instr[`EABR_LONG_BIT];
    o_dec.ra_sel = i_instr[`EABR_RA_HI:`EABR_RA_LO];
    o_dec.rb_sel = i_instr[`EABR_RB_HI:`EABR_RB_LO];
    o_dec.literal = i_instr[15:0];
  end
endmodule

// ---- hw/eabr_unit.sv ----
// Purpose: Executes extended-address less-than and not-equal branches
// Assumes: Register file reads are supplied by the pipeline each issue
// Notes: Outputs are registered; busy marks the stall cycles
`timescale 1ns/1ps
`include "eabr_consts.svh"
module eabr_unit
#(
  parameter logic [1:0] AREA_OPTIMIZATION_SETTING = 2'h0
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Issue
  input wire logic i_issue,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_pc,
  input wire logic i_predict_taken,
  // Prefix from preceding extension instruction
  input wire logic i_prefix_valid,
  input wire logic i_prefix_long,
  input wire logic [47:0] i_prefix_value,
  // Register file read data
  input wire logic [63:0] i_condition_operand_register,
  input wire logic [63:0] i_offset_register,
  // Result
  output logic o_done,
  output logic o_taken,
  output logic [63:0] o_next_pc,
  output logic o_squash_next,
  output logic o_mispredict,
  output logic o_busy,
  output logic [3:0] o_latency,
  output logic o_reg_write
);
  // ****************************************
  // Decode
  // ****************************************
  eabr_pkg::eabr_decode_type dec;
  eabr_pkg::eabr_state_type state;
  logic [3:0] stall_cnt;
  logic [63:0] imm_ext;
  logic [63:0] offset;
  logic cond_neg;
  logic cond_nz;
  logic use_long;
  logic take;
  logic accept;
  logic [63:0] next_pc;
  logic [3:0] next_lat;
  logic mispredict;

  eabr_decode u_decode
  (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  assign accept = i_issue && dec.valid && (state == eabr_pkg::EABR_IDLE_TYPE_S);

  // ****************************************
  // Operand formation
  // ****************************************
  always_comb
  begin
    if (i_prefix_valid && i_prefix_long)
      imm_ext = {i_prefix_value, dec.literal};
    else if (i_prefix_valid)
      imm_ext = {{32{i_prefix_value[15]}}, i_prefix_value[15:0],
        dec.literal};
    else
      imm_ext = {{48{dec.literal[15]}}, dec.literal};
    offset = dec.imm_form ? imm_ext : i_offset_register;
    use_long = dec.imm_form ? (i_prefix_valid && i_prefix_long)
      : dec.long_cmp;
    cond_neg = use_long ? i_condition_operand_register[63]
      : i_condition_operand_register[31];
    cond_nz = use_long ? (i_condition_operand_register != 64'h0)
      : (i_condition_operand_register[31:0] != 32'h0);
    take = dec.is_lt ? cond_neg : cond_nz;
    next_pc = take ? i_pc + offset : i_pc + `EABR_PC_STEP;
    mispredict = dec.imm_form && (i_predict_taken != take);
  end

  // ****************************************
  // Latency selection
  // ****************************************
  always_comb
  begin
    if (dec.imm_form && mispredict)
      next_lat = (AREA_OPTIMIZATION_SETTING == 2'h2) ? `EABR_LAT_MISP_A2
        : `EABR_LAT_MISP_A0;
    else if (!take || (dec.imm_form && i_predict_taken))
      next_lat = `EABR_LAT_NOT_TAKEN;
    else if (dec.dslot)
      next_lat = `EABR_LAT_DSLOT;
    else
      next_lat = `EABR_LAT_NODSLOT;
  end

  // ****************************************
  // Stall state machine
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= eabr_pkg::EABR_IDLE_TYPE_S;
      stall_cnt <= 4'h0;
    end
    else
    begin
      unique case (state)
        eabr_pkg::EABR_IDLE_TYPE_S:
        begin
          if (accept && next_lat > `EABR_LAT_NOT_TAKEN)
          begin
            state <= eabr_pkg::EABR_STALL;
            stall_cnt <= next_lat - 4'h1;
          end
        end
        eabr_pkg::EABR_STALL:
        begin
          if (stall_cnt == 4'h1)
            state <= eabr_pkg::EABR_IDLE_TYPE_S;
          stall_cnt <= stall_cnt - 4'h1;
        end
        default:
          state <= eabr_pkg::EABR_IDLE_TYPE_S;
      endcase
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_done <= 1'b0;
      o_taken <= 1'b0;
      o_next_pc <= `EABR_PC_RESET;
      o_squash_next <= 1'b0;
      o_mispredict <= 1'b0;
      o_latency <= 4'h0;
    end
    else
    begin
      o_done <= accept;
      if (accept)
      begin
        o_taken <= take;
        o_next_pc <= next_pc;
        o_squash_next <= take && !dec.dslot;
        o_mispredict <= mispredict;
        o_latency <= next_lat;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_busy <= 1'b0;
    else if (state == eabr_pkg::EABR_IDLE_TYPE_S)
      o_busy <= accept && (next_lat > `EABR_LAT_NOT_TAKEN);
    else
      o_busy <= (stall_cnt != 4'h1);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reg_write <= 1'b0;
    else
      o_reg_write <= 1'b0;
  end
endmodule

// ---- pkg/eabr_consts.svh ----
// Purpose: Constants for the extended-address branch unit
// Assumes: Instruction bit 0 is the most significant bit (bit 31 in RTL)
// Notes: Field positions are given in RTL little-endian numbering
`ifndef EABR_CONSTS_SVH
`define EABR_CONSTS_SVH
`define EABR_OPC_REG 6'h27
`define EABR_OPC_IMM 6'h2f
`define EABR_OPC_HI 31
`define EABR_OPC_LO 26
`define EABR_DSLOT_BIT 25
`define EABR_EA_HI 24
`define EABR_EA_LO 23
`define EABR_EA_VAL 2'h2
`define EABR_COND_HI 22
`define EABR_COND_LO 21
`define EABR_COND_LT 2'h2
`define EABR_COND_NE 2'h1
`define EABR_RA_HI 20
`define EABR_RA_LO 16
`define EABR_RB_HI 15
`define EABR_RB_LO 11
`define EABR_LONG_BIT 8
`define EABR_ZERO_HI 10
`define EABR_ZERO_LO 0
`define EABR_PC_STEP 64'h0000_0000_0000_0004
`define EABR_LAT_NOT_TAKEN 4'h1
`define EABR_LAT_DSLOT 4'h2
`define EABR_LAT_NODSLOT 4'h3
`define EABR_LAT_MISP_A0 4'h3
`define EABR_LAT_MISP_A2 4'h8
`define EABR_PC_RESET 64'h0000_0000_0000_0000
`endif

// ---- pkg/eabr_pkg.sv ----
// Purpose: Types for the extended-address branch unit
// Assumes: 64-bit datapath
// Notes: Constants live in eabr_consts.svh
package eabr_pkg;
  typedef enum logic [1:0] {
    EABR_IDLE_TYPE_S = 2'b00,
    EABR_STALL = 2'b01
  } eabr_state_type;

  typedef struct packed {
    logic valid;
    logic imm_form;
    logic is_lt;
    logic dslot;
    logic long_cmp;
    logic [4:0] ra_sel;
    logic [4:0] rb_sel;
    logic [15:0] literal;
  } eabr_decode_type;

  typedef struct packed {
    logic valid;
    logic is_long;
    logic [47:0] value;
  } eabr_prefix_type;
endpackage

// ---- tb/eabr_unit_properties.sv ----
// Purpose: Port checks for eabr_unit
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every eabr_unit instance
`timescale 1ns/1ps
module eabr_chk
#(
  parameter logic [1:0] AREA_OPTIMIZATION_SETTING = 2'h0
)
(
  // Inputs
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_pc,
  input wire logic [63:0] i_condition_operand_register,
  input wire logic [63:0] i_offset_register,
  // Outputs
  input wire logic o_done,
  input wire logic o_taken,
  input wire logic [63:0] o_next_pc,
  input wire logic o_squash_next,
  input wire logic o_mispredict,
  input wire logic o_busy,
  input wire logic [3:0] o_latency,
  input wire logic o_reg_write
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_busy_three: assert property (
    o_done && o_latency == 4'h3 |-> o_busy ##1 o_busy ##1 !o_busy)
    else $error("three-cycle stall wrong");
  a_busy_two: assert property (
    o_done && o_latency == 4'h2 |-> o_busy ##1 !o_busy)
    else $error("two-cycle stall wrong");
  a_busy_one: assert property (
    o_done && o_latency == 4'h1 |-> !o_busy)
    else $error("single cycle stalled");
  a_fall_through: assert property (
    o_done && !o_taken |-> o_next_pc == $past(i_pc) + 64'h4)
    else $error("fall-through pc wrong");
  a_reg_target: assert property (
    o_done && o_taken && $past(i_instr[31:26]) == 6'h27 |->
    o_next_pc == $past(i_pc) + $past(i_offset_register))
    else $error("register target wrong");
  a_slot_squash: assert property (
    o_done |-> o_squash_next == (o_taken && !$past(i_instr[25])))
    else $error("squash wrong");
  a_ne_taken: assert property (
    o_done && $past(i_instr[31:26]) == 6'h27 &&
    $past(i_instr[22:21]) == 2'h1 |-> o_taken == ($past(i_instr[8]) ?
    $past(i_condition_operand_register) != 64'h0 :
    $past(i_condition_operand_register[31:0]) != 32'h0))
    else $error("not-equal outcome wrong");
  a_no_write: assert property (
    !o_reg_write)
    else $error("register write seen");
  c_slot: cover property (o_done && o_taken && !o_squash_next);
  c_miss: cover property (o_done && o_mispredict);
  c_fall: cover property (o_done && !o_taken);
endmodule
bind eabr_unit eabr_chk
  #(.AREA_OPTIMIZATION_SETTING(AREA_OPTIMIZATION_SETTING)) u_chk (.*);

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for eabr_unit
// Assumes: Area setting 0
// Notes: Results are matched in issue order
`timescale 1ns/1ps
`include "eabr_consts.svh"
module tb_top;
  logic i_core_clk, i_reset_n, i_issue, i_predict_taken, i_prefix_valid;
  logic i_prefix_long, o_done, o_taken, o_squash_next, o_mispredict;
  logic o_busy, o_reg_write;
  logic [2:0] r;
  logic [3:0] o_latency;
  logic [31:0] i_instr, w;
  logic [47:0] i_prefix_value;
  logic [63:0] i_pc, i_condition_operand_register, i_offset_register;
  logic [63:0] o_next_pc;
  logic [71:0] q[$];
  logic [71:0] e;
  int failures, checks_done;
  eabr_unit uut (.*);
  task automatic end_sim();
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
    if (o_done === 1'b1)
    begin
      checks_done++;
      e = q.size() > 0 ? q.pop_front() : 'x;
      if ({o_taken, o_next_pc, o_squash_next, o_mispredict, o_latency,
        o_reg_write} !== e)
      begin
        failures++;
        $display("MISMATCH %0t expected %h", $time, e);
      end
    end
  // Issues one word; f is predict, prefix present, prefix long
  task automatic br(input logic [31:0] w, input logic [2:0] f, input bit ok);
    logic [63:0] a, b, pc, pv, im, c;
    logic t, m, ii;
    logic [3:0] l;
    a = {$urandom, $urandom};
    b = {$urandom, $urandom};
    pc = {$urandom, $urandom};
    pv = {$urandom, $urandom};
    case (3'($urandom % 5))
      3'h0: a = '0;
      3'h1: a = 64'h0000_0001_0000_0000;
      3'h2: a = 64'h0000_0000_8000_0000;
      default: ;
    endcase
    ii = w[31:26] == `EABR_OPC_IMM;
    im = !f[1] ? {{48{w[15]}}, w[15:0]} :
      f[0] ? {pv[47:0], w[15:0]} : {{32{pv[15]}}, pv[15:0], w[15:0]};
    c = (ii ? f[1] & f[0] : w[8]) ? a : {{32{a[31]}}, a[31:0]};
    t = w[22] ? c[63] : c != 64'h0;
    m = ii && t != f[2];
    l = m ? 4'h3 : !t || ii ? 4'h1 : w[25] ? 4'h2 : 4'h3;
    if (ok)
      q.push_back({t, t ? pc + (ii ? im : b) : pc + 64'h4, t & ~w[25], m,
        l, 1'b0});
    @(posedge i_core_clk);
    i_issue <= 1'b1;
    i_instr <= w;
    i_pc <= pc;
    {i_predict_taken, i_prefix_valid, i_prefix_long} <= f;
    i_prefix_value <= pv[47:0];
    i_condition_operand_register <= a;
    i_offset_register <= b;
    @(posedge i_core_clk);
    // A held issue during the stall must be ignored
    if (l > 4'h1 && 1'($urandom))
      @(posedge i_core_clk);
    i_issue <= 1'b0;
    i_instr <= ~w;
    for (int k = 0; k < 20; k++)
    begin
      @(negedge i_core_clk);
      if (k > 2 && q.size() == 0 && o_busy === 1'b0)
        return;
    end
    failures++;
    $display("MISMATCH %0t no result", $time);
    end_sim();
  endtask
  initial
  begin
    {i_issue, i_predict_taken, i_prefix_valid, i_prefix_long} = 4'h0;
    {i_instr, i_prefix_value, i_pc} = '0;
    {i_condition_operand_register, i_offset_register} = '0;
    i_reset_n = 1'b0;
    void'($urandom(32'h965dfdc1));
    repeat (16) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (300)
    begin
      r = 3'($urandom);
      w = $urandom;
      w[31:21] = {r[0] ? `EABR_OPC_IMM : `EABR_OPC_REG, r[1], 2'h2,
        r[2] ? `EABR_COND_LT : `EABR_COND_NE};
      if (!r[0])
        w[10:0] = {2'h0, w[8], 8'h00};
      br(w, {r[0] & (r[1] | 1'($urandom)), r[0] & 1'($urandom),
        1'($urandom)}, 1'b1);
    end
    br({6'h26, w[25:0]}, 3'h0, 1'b0);
    br({w[31:23], 2'h0, w[20:0]}, 3'h0, 1'b0);
    br({w[31:23], 2'h3, w[20:0]}, 3'h0, 1'b0);
    br({w[31:25], 2'h1, w[22:0]}, 3'h0, 1'b0);
    br({`EABR_OPC_REG, 5'h09, 21'h000001}, 3'h0, 1'b0);
    end_sim();
  end
endmodule
